// *** a429rx_pkg.sv ***
// shared constants and carriers for the arinc 429 receive path
package a429rx_pkg;
    localparam int SR_LEN          = 10;
    localparam int HALF_LEN        = 5;
    localparam int RUN_LEN         = 3;
    localparam int WORD_BITS       = 32;
    localparam int BIT_MIN_SMP     = 8;
    localparam int BIT_MAX_SMP     = 12;
    localparam int GAP_NEED        = 3;
    localparam int REF_HZ          = 1_000_000;
    localparam int SYS_HZ          = 100_000_000;
    localparam int REF_DIV         = SYS_HZ / REF_HZ;
    localparam int HS_SMP_DIV      = 1;
    localparam int LS_SMP_DIV      = 8;
    localparam int HS_GAP_CLK      = 10;
    localparam int LS_GAP_CLK      = 80;
    localparam int FIFO_DEPTH      = 32;
    localparam int FIFO_HALF       = 16;
    localparam int BUF_DEPTH       = 4;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        A429RX_IDLE = 2'b00,
        A429RX_BITS = 2'b01,
        A429RX_GAP  = 2'b11
    } a429rx_state_type;

    typedef struct packed {
        logic is_one;
        logic is_zero;
        logic is_null;
    } a429rx_line_type;

    typedef struct packed {
        logic label_order_sel;
        logic label_filter_en;
        logic sdi_decode_en;
        logic sdi_match_b10;
        logic sdi_match_b9;
        logic rx_parity_check_en;
        logic rx_flag_sel;
        logic low_speed;
    } a429rx_cfg_type;
endpackage

// *** a429rx_top.sv ***
// arinc 429 receive path: sampling, validation, filter, fifo, host mapping
//
// How it works
// RULE1: order select clear: host 1=bit32, 2-22=31..11, 23-24=10,9, 25-32=1..8.
// RULE2: order select set: same upper 24, positions 25-32 carry bits 8..1.
// RULE3: bit timing is validated from samples on a 1 mhz reference.
// RULE4: three 10-bit shift registers for one, zero, null; matching band shifts 1.
// RULE5: input between bands shifts a 0 into all three registers.
// RULE6: data bit needs three ones upper half one/zero, three lower half null.
// RULE7: word gap null needs three ones in both halves of null register.
// RULE8: bits follow previous bit by 8 to 12 samples, else reject.
// RULE9: signal outside defined bands rejects the data.
// RULE10: after last bit, gap timer samples null every 10 (80) clocks, counts.
// RULE11: no new word accepted until gap count reaches 3.
// RULE12: after 32 valid bits a one-cycle word complete strobe is raised.
// RULE13: load only if enabled label and sdi checks pass; else drop silently.
// RULE14: loaded word sets data ready and clears empty until fifo drained.
// RULE15: one fifo entry pops per host read-word request.
// RULE16: fifo holds 32 words; full flag set at 32.
// RULE17: when full, new accepted words overwrite location 32.
// RULE18: half flag set when fifo holds 16 or more words.
// RULE19: parity check off: bit 32 stored as received.
// RULE20: parity check on: bit 32 becomes 0 for odd word, 1 for even.
// RULE21: decoder enable compares bits 10 and 9 to two match bits.
// RULE22: flag pin follows empty when select 0, full when select 1.
// RULE23: 256-entry label table marks each label accepted or discarded.
// RULE24: reading an empty fifo returns all zeros.
// RULE25: a speed input scales sample interval and gap timer.
// RULE26: bits shift in arinc order 1 to 32 as received.
`timescale 1ns/1ns

module a429rx_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } a429rx_buf_type;
    a429rx_buf_type st_r, st_nxt;
    logic push, pop;

    assign in_ready_o  = st_r.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = st_r.cnt != '0;
    assign out_data_o  = st_r.mem[st_r.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data_i;
            st_nxt.wr = (st_r.wr == AW'(DEPTH-1)) ? '0 : st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = (st_r.rd == AW'(DEPTH-1)) ? '0 : st_r.rd + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

module a429rx_top (
    // clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    // comparator outputs from line receiver
    input  wire logic                      line_one_i,
    input  wire logic                      line_zero_i,
    input  wire logic                      line_null_i,
    // configuration
    input  wire a429rx_pkg::a429rx_cfg_type cfg_i,
    // label table load
    input  wire logic                      lut_we_i,
    input  wire logic [7:0]                lut_addr_i,
    input  wire logic                      lut_data_i,
    // host word read
    input  wire logic                      rd_req_i,
    output logic [31:0]                    rd_data_o,
    output logic                           rd_valid_o,
    // status
    output logic                           rx_fifo_empty_o,
    output logic                           rx_fifo_half_o,
    output logic                           rx_fifo_full_o,
    output logic                           rx_flag_pin_o,
    output logic                           data_ready_o,
    output logic                           word_complete_strobe_o
);
    typedef struct packed {
        logic [2:0][2:0]  sync;
        logic [2:0]       held;
        logic [6:0]       refcnt;
        logic [2:0]       smpcnt;
        logic [9:0]       sr_one;
        logic [9:0]       sr_zero;
        logic [9:0]       sr_null;
        a429rx_pkg::a429rx_state_type fsm;
        logic             armed;
        logic [3:0]       since;
        logic [5:0]       nbits;
        logic [31:0]      shreg;
        logic [6:0]       gapclk;
        logic [1:0]       gapcnt;
        logic             word_complete_strobe;
        logic [31:0]      word;
        logic             ready;
        logic [31:0]      rdat;
        logic             rval;
    } a429rx_st_type;

    a429rx_st_type st_r, st_nxt;
    logic [255:0] lut_r;
    logic [31:0]  fifo_mem [a429rx_pkg::FIFO_DEPTH];
    logic [5:0]   fcnt_r;
    logic [4:0]   fwr_r;
    logic [4:0]   frd_r;

    logic        tick, smp, b_one, b_zero, nul_low, gap_null;
    logic [2:0]  ln, smp_last;
    logic [6:0]  gap_last;
    logic        bin_valid, bin_ready, bout_valid, bout_ready;
    logic [31:0] bout_data, host_word, stored;
    logic        label_ok, sdi_ok, accept;
    logic        do_pop, do_push;

    function automatic logic run3(input logic [4:0] h);
        run3 = (h[4] & h[3] & h[2]) | (h[3] & h[2] & h[1]) | (h[2] & h[1] & h[0]);
    endfunction

    // samples only update once the last two stages agree
    // a one-clock disagreement keeps the last agreed band, not a false between-band sample
    assign ln = (st_r.sync[1] == st_r.sync[2]) ? st_r.sync[2] : st_r.held;
    assign tick = st_r.refcnt == 7'(a429rx_pkg::REF_DIV - 1); // RULE3
    assign smp_last = cfg_i.low_speed ? 3'(a429rx_pkg::LS_SMP_DIV - 1)
                                      : 3'(a429rx_pkg::HS_SMP_DIV - 1); // RULE25
    assign gap_last = cfg_i.low_speed ? 7'(a429rx_pkg::LS_GAP_CLK - 1)
                                      : 7'(a429rx_pkg::HS_GAP_CLK - 1); // RULE25
    assign smp = tick && (st_r.smpcnt == smp_last); // RULE25
    assign b_one   = run3(st_r.sr_one[9:5]); // RULE6
    assign b_zero  = run3(st_r.sr_zero[9:5]); // RULE6
    assign nul_low = run3(st_r.sr_null[4:0]); // RULE6
    assign gap_null = run3(st_r.sr_null[9:5]) && nul_low; // RULE7

    assign label_ok = !cfg_i.label_filter_en || lut_r[st_r.word[7:0]]; // RULE13 RULE23
    assign sdi_ok = !cfg_i.sdi_decode_en ||
                    (st_r.word[9] == cfg_i.sdi_match_b10 &&
                     st_r.word[8] == cfg_i.sdi_match_b9); // RULE13 RULE21
    assign accept = st_r.word_complete_strobe && label_ok && sdi_ok;
    // parity flag: 1 on even parity over all 32 bits
    assign stored = cfg_i.rx_parity_check_en ?
                    {~^st_r.word, st_r.word[30:0]} : st_r.word; // RULE19 RULE20

    always_comb begin
        logic [2:0] band;
        band = 3'h0;
        st_nxt = st_r;
        st_nxt.word_complete_strobe = 1'b0;
        st_nxt.rval = 1'b0;
        st_nxt.sync[0] = {line_one_i, line_zero_i, line_null_i};
        st_nxt.sync[1] = st_r.sync[0];
        st_nxt.sync[2] = st_r.sync[1];
        st_nxt.held = ln;
        st_nxt.refcnt = tick ? 7'h00 : st_r.refcnt + 7'h01;
        if (tick) begin
            st_nxt.smpcnt = smp ? 3'h0 : st_r.smpcnt + 3'h1;
        end
        // conflicting comparator codes count as between bands
        if (ln == 3'b100 || ln == 3'b010 || ln == 3'b001) begin
            band = ln; // RULE4
        end
        if (smp) begin
            st_nxt.sr_one  = {st_r.sr_one[8:0], band[2]}; // RULE4 RULE5
            st_nxt.sr_zero = {st_r.sr_zero[8:0], band[1]}; // RULE4 RULE5
            st_nxt.sr_null = {st_r.sr_null[8:0], band[0]}; // RULE4 RULE5
            if (st_r.since != 4'hF) begin
                st_nxt.since = st_r.since + 4'h1;
            end
        end
        case (st_r.fsm)
            a429rx_pkg::A429RX_IDLE: begin
                st_nxt.armed = 1'b0;
                st_nxt.nbits = '0;
                if (smp && (b_one || b_zero) && nul_low) begin
                    st_nxt.fsm = a429rx_pkg::A429RX_BITS;
                end
            end
            a429rx_pkg::A429RX_BITS: begin
                if (smp) begin
                    if (band == 3'b000 && !st_r.armed) begin
                        st_nxt.fsm = a429rx_pkg::A429RX_IDLE; // RULE9
                    end else if ((b_one || b_zero) && nul_low && !st_r.armed) begin
                        if (st_r.nbits != 6'h0 &&
                            (st_r.since < 4'(a429rx_pkg::BIT_MIN_SMP) ||
                             st_r.since > 4'(a429rx_pkg::BIT_MAX_SMP))) begin
                            st_nxt.fsm = a429rx_pkg::A429RX_IDLE; // RULE8
                        end else begin
                            st_nxt.shreg = {b_one, st_r.shreg[31:1]}; // RULE26
                            st_nxt.nbits = st_r.nbits + 6'h1;
                            st_nxt.since = 4'h0;
                            st_nxt.armed = 1'b1;
                            if (st_r.nbits == 6'(a429rx_pkg::WORD_BITS - 1)) begin
                                st_nxt.word_complete_strobe = 1'b1; // RULE12
                                st_nxt.word = {b_one, st_r.shreg[31:1]};
                                st_nxt.fsm = a429rx_pkg::A429RX_GAP;
                                st_nxt.gapclk = '0;
                                st_nxt.gapcnt = '0;
                            end
                        end
                    end else if (!nul_low) begin
                        st_nxt.armed = 1'b0;
                    end
                    if (st_r.nbits != 6'h0 && st_r.since > 4'(a429rx_pkg::BIT_MAX_SMP)) begin
                        st_nxt.fsm = a429rx_pkg::A429RX_IDLE; // RULE8
                    end
                end
            end
            a429rx_pkg::A429RX_GAP: begin
                if (tick) begin
                    if (st_r.gapclk == gap_last) begin
                        st_nxt.gapclk = '0; // RULE10 RULE25
                        if (gap_null) begin
                            st_nxt.gapcnt = st_r.gapcnt + 2'h1; // RULE10
                            if (st_r.gapcnt == 2'(a429rx_pkg::GAP_NEED - 1)) begin
                                st_nxt.fsm = a429rx_pkg::A429RX_IDLE; // RULE11
                            end
                        end
                    end else begin
                        st_nxt.gapclk = st_r.gapclk + 7'h01;
                    end
                end
            end
            default: st_nxt.fsm = a429rx_pkg::A429RX_IDLE;
        endcase
        if (accept) begin
            st_nxt.ready = 1'b1; // RULE14
        end else if (do_pop && fcnt_r == 6'h1 && !do_push) begin
            st_nxt.ready = 1'b0;
        end
        if (rd_req_i) begin
            st_nxt.rval = 1'b1;
            st_nxt.rdat = do_pop ? host_word : a429rx_pkg::RST_WORD; // RULE15 RULE24
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lut_r <= '0;
        end else if (lut_we_i) begin
            lut_r[lut_addr_i] <= lut_data_i; // RULE23
        end
    end

    // small buffer between the filter and the host fifo
    a429rx_buf #(
        .WIDTH (32),
        .DEPTH (a429rx_pkg::BUF_DEPTH)
    ) u_buf (
        .sys_clk_i   (sys_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (bin_valid),
        .in_ready_o  (bin_ready),
        .in_data_i   (stored),
        .out_valid_o (bout_valid),
        .out_ready_i (bout_ready),
        .out_data_o  (bout_data)
    );
    // a word arrives at most once every 278 samples, so the buffer never refuses one
    assign bin_valid  = accept;
    // a read in the same cycle holds off the push to keep one port per cycle
    assign bout_ready = !rd_req_i;
    assign do_push    = bout_valid && bout_ready;
    assign do_pop     = rd_req_i && fcnt_r != 6'h0;

    // host bit order mapping, position 1 is bit 31 of the host word
    always_comb begin
        logic [31:0] w;
        w = fifo_mem[frd_r];
        host_word[31]    = w[31]; // RULE1
        host_word[30:10] = w[30:10]; // RULE1
        host_word[9:8]   = w[9:8]; // RULE1
        for (int i = 0; i < 8; i++) begin
            host_word[7 - i] = cfg_i.label_order_sel ? w[7 - i] : w[i]; // RULE1 RULE2
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fcnt_r <= '0;
            fwr_r  <= '0;
            frd_r  <= '0;
        end else begin
            if (do_push) begin
                if (fcnt_r == 6'(a429rx_pkg::FIFO_DEPTH)) begin
                    fifo_mem[5'(frd_r - 5'h1)] <= bout_data; // RULE17
                end else begin
                    fifo_mem[fwr_r] <= bout_data;
                    fwr_r <= fwr_r + 5'h1;
                    fcnt_r <= fcnt_r + 6'h1; // RULE16
                end
            end
            if (do_pop) begin
                frd_r <= frd_r + 5'h1; // RULE15
                fcnt_r <= fcnt_r - 6'h1;
            end
        end
    end

    assign rx_fifo_empty_o = fcnt_r == 6'h0; // RULE14
    assign rx_fifo_full_o  = fcnt_r == 6'(a429rx_pkg::FIFO_DEPTH); // RULE16
    assign rx_fifo_half_o  = fcnt_r >= 6'(a429rx_pkg::FIFO_HALF); // RULE18
    assign rx_flag_pin_o   = cfg_i.rx_flag_sel ? rx_fifo_full_o : rx_fifo_empty_o; // RULE22
    assign data_ready_o    = st_r.ready;
    assign word_complete_strobe_o = st_r.word_complete_strobe;
    assign rd_data_o  = st_r.rdat;
    assign rd_valid_o = st_r.rval;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    eos_one_cycle_a: assert property (st_r.word_complete_strobe |=> !st_r.word_complete_strobe) // RULE12
        else $error("strobe longer than one cycle");
    eos_to_gap_a: assert property (st_r.word_complete_strobe |-> st_r.fsm == a429rx_pkg::A429RX_GAP) // RULE11
        else $error("strobe without gap wait");
    gap_leave_a: assert property (st_r.fsm == a429rx_pkg::A429RX_GAP && // RULE11
                                  st_nxt.fsm == a429rx_pkg::A429RX_IDLE
                                  |-> st_r.gapcnt == 2'h2 && gap_null)
        else $error("gap left early");
    full_flag_a: assert property (rx_fifo_full_o == (fcnt_r == 6'h20)) // RULE16
        else $error("full flag wrong");
    half_flag_a: assert property (rx_fifo_half_o == (fcnt_r > 6'h0F)) // RULE18
        else $error("half flag wrong");
    flag_pin_a: assert property (cfg_i.rx_flag_sel |-> rx_flag_pin_o == rx_fifo_full_o) // RULE22
        else $error("flag pin wrong");
    empty_read_a: assert property (rd_req_i && fcnt_r == 6'h0 |=> // RULE24
                                   rd_valid_o && rd_data_o == '0)
        else $error("empty read not zero");
    pop_count_a: assert property (do_pop && !do_push |=> fcnt_r == $past(fcnt_r) - 6'h1) // RULE15
        else $error("pop did not decrement");
    full_stays_a: assert property (rx_fifo_full_o && do_push && !do_pop |=> // RULE17
                                   rx_fifo_full_o)
        else $error("overwrite changed count");
    drop_a: assert property (st_r.word_complete_strobe && !label_ok |-> !bin_valid) // RULE13
        else $error("filtered word loaded");
    buf_room_a: assert property (bin_valid |-> bin_ready) // RULE14
        else $error("buffer refused a word");
    parity_a: assert property (accept && cfg_i.rx_parity_check_en |-> // RULE20
                               stored[31] != (^st_r.word))
        else $error("parity flag wrong");
    ready_set_a: assert property (accept |=> data_ready_o) // RULE14
        else $error("data ready not set");

    word_seen_c: cover property (st_r.word_complete_strobe);
    word_loaded_c: cover property (accept ##[1:20] rx_fifo_empty_o == 1'b0);
    fifo_full_c: cover property (rx_fifo_full_o);
    word_read_c: cover property (do_pop);
endmodule

// *** a429rx_xmit_model.sv ***
// behavioural remote transmitter driving the comparator band levels
`timescale 1ns/1ns

module a429rx_xmit_model (
    // clock
    input  wire logic        sys_clk_i,
    // word request
    input  wire logic        start_i,
    input  wire logic [31:0] word_i,
    input  wire logic [5:0]  bad_bit_i,
    // comparator bands
    output logic             line_one_o,
    output logic             line_zero_o,
    output logic             line_null_o,
    output logic             busy_o
);
    // five 1 mhz samples per half bit at high speed
    localparam int HALF_CLK = 500;

    initial begin
        line_one_o  = 1'b0;
        line_zero_o = 1'b0;
        line_null_o = 1'b1;
        busy_o      = 1'b0;
    end

    always begin
        @(posedge sys_clk_i);
        if (start_i === 1'b1) begin
            busy_o <= 1'b1;
            for (int b = 1; b <= 32; b++) begin
                if (bad_bit_i == 6'(b)) begin
                    // two bands at once reads as between bands
                    line_one_o  <= 1'b1;
                    line_zero_o <= 1'b1;
                    line_null_o <= 1'b0;
                    repeat (HALF_CLK) @(posedge sys_clk_i);
                    break;
                end
                line_one_o  <= word_i[b-1];
                line_zero_o <= ~word_i[b-1];
                line_null_o <= 1'b0;
                repeat (HALF_CLK) @(posedge sys_clk_i);
                line_one_o  <= 1'b0;
                line_zero_o <= 1'b0;
                line_null_o <= 1'b1;
                repeat (HALF_CLK) @(posedge sys_clk_i);
            end
            line_one_o  <= 1'b0;
            line_zero_o <= 1'b0;
            line_null_o <= 1'b1;
            // four bit times of null, enough for a gap count of 3
            repeat (8 * HALF_CLK) @(posedge sys_clk_i);
            busy_o <= 1'b0;
        end
    end
endmodule

// *** arinc429_receive_path_test.sv ***
// self-checking testbench for the arinc 429 receive path
`timescale 1ns/1ns

module arinc429_receive_path_test;
    logic                    sys_clk_i = 1'b0;
    logic                    reset_n_i = 1'b0;
    logic                    line_one, line_zero, line_null, busy;
    a429rx_pkg::a429rx_cfg_type cfg = '0;
    logic                    lut_we_i = 1'b0;
    logic [7:0]              lut_addr_i = 8'h00;
    logic                    lut_data_i = 1'b0;
    logic                    rd_req_i = 1'b0;
    logic                    start = 1'b0;
    logic [31:0]             tx_word = 32'h0000_0000;
    logic [5:0]              bad_bit = 6'h00;
    logic [31:0]             rd_data, d;
    logic                    rd_valid, empty, half, full, flag, ready, strobe;
    int                      fails = 0;
    int                      total_checks = 0;
    int                      strobes = 0;
    localparam logic [31:0]  WORD_A = 32'hA5C3_1E8D;
    // label 81 reads the same in either bit order; even parity
    localparam logic [31:0]  WORD_B = 32'h3C96_A581;

    always #5 sys_clk_i = ~sys_clk_i;

    a429rx_top dut (
        .sys_clk_i              (sys_clk_i),
        .reset_n_i              (reset_n_i),
        .line_one_i             (line_one),
        .line_zero_i            (line_zero),
        .line_null_i            (line_null),
        .cfg_i                  (cfg),
        .lut_we_i               (lut_we_i),
        .lut_addr_i             (lut_addr_i),
        .lut_data_i             (lut_data_i),
        .rd_req_i               (rd_req_i),
        .rd_data_o              (rd_data),
        .rd_valid_o             (rd_valid),
        .rx_fifo_empty_o        (empty),
        .rx_fifo_half_o         (half),
        .rx_fifo_full_o         (full),
        .rx_flag_pin_o          (flag),
        .data_ready_o           (ready),
        .word_complete_strobe_o (strobe)
    );

    a429rx_xmit_model far (
        .sys_clk_i   (sys_clk_i),
        .start_i     (start),
        .word_i      (tx_word),
        .bad_bit_i   (bad_bit),
        .line_one_o  (line_one),
        .line_zero_o (line_zero),
        .line_null_o (line_null),
        .busy_o      (busy)
    );

    always @(posedge sys_clk_i) begin
        if (strobe === 1'b1) begin
            strobes++;
        end
    end

    task automatic check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] host_map(input logic [31:0] w, input logic sel,
                                             input logic par);
        logic [31:0] h;
        h = w;
        if (!sel) begin
            for (int k = 0; k < 8; k++) begin
                h[7-k] = w[k];
            end
        end
        if (par) begin
            h[31] = ~(^w);
        end
        return h;
    endfunction

    task automatic read_word(output logic [31:0] data);
        @(posedge sys_clk_i);
        rd_req_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_req_i <= 1'b0;
        #1;
        check_bit("rd_valid", 1'b1, rd_valid);
        data = rd_data;
    endtask

    // the model runs one word plus its gap; bounded wait
    task automatic send(input logic [31:0] w, input logic [5:0] bad);
        @(posedge sys_clk_i);
        tx_word <= w;
        bad_bit <= bad;
        start   <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        #1;
        for (int n = 0; n < 40000 && busy === 1'b1; n++) begin
            @(posedge sys_clk_i);
        end
        #1;
        check_bit("model_done", 1'b0, busy);
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #950_000;
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check_bit("empty_rst", 1'b1, empty);
        check_bit("flag_rst", 1'b1, flag);
        check_bit("half_rst", 1'b0, half);
        check_bit("full_rst", 1'b0, full);
        check_bit("ready_rst", 1'b0, ready);
        read_word(d);
        check_word("empty_read", 32'h0000_0000, d);
        check_bit("empty_no_pop", 1'b1, empty);
        send(WORD_A, 6'h00);
        check_word("strobes_a", 32'h0000_0001, 32'(strobes));
        check_bit("empty_a", 1'b0, empty);
        check_bit("ready_a", 1'b1, ready);
        check_bit("flag_a", 1'b0, flag);
        check_bit("half_a", 1'b0, half);
        cfg.rx_flag_sel <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check_bit("flag_full_sel", 1'b0, flag);
        read_word(d);
        check_word("word_a", host_map(WORD_A, 1'b0, 1'b0), d);
        check_bit("empty_drained", 1'b1, empty);
        check_bit("ready_drained", 1'b0, ready);
        check_bit("flag_sel_empty", 1'b0, flag);
        // between-band sample in bit 3 must abandon the word
        send(32'hFFFF_FFFF, 6'h03);
        check_word("strobes_abort", 32'h0000_0001, 32'(strobes));
        check_bit("empty_abort", 1'b1, empty);
        @(posedge sys_clk_i);
        lut_we_i   <= 1'b1;
        lut_addr_i <= 8'h81;
        lut_data_i <= 1'b1;
        cfg.label_order_sel    <= 1'b1;
        cfg.label_filter_en    <= 1'b1;
        cfg.sdi_decode_en      <= 1'b1;
        cfg.sdi_match_b10      <= 1'b0;
        cfg.sdi_match_b9       <= 1'b1;
        cfg.rx_parity_check_en <= 1'b1;
        cfg.rx_flag_sel        <= 1'b0;
        @(posedge sys_clk_i);
        lut_we_i <= 1'b0;
        send(WORD_B, 6'h00);
        check_word("strobes_b", 32'h0000_0002, 32'(strobes));
        check_bit("empty_b", 1'b0, empty);
        read_word(d);
        check_word("word_b", host_map(WORD_B, 1'b1, 1'b1), d);
        tally_and_finish();
    end
endmodule
